// *** design/dps_params.svh ***
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH

// Clock period of the controller clock, in nanoseconds.
`define DPS_CLK_PERIOD_NS 25
// Longest access time of the memory port, in nanoseconds.
`define DPS_T_ACCESS_NS 55
// Cycles that the strobe phase lasts, rounded up to whole cycles.
`define DPS_ACCESS_CYC \
    ((`DPS_T_ACCESS_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
// Width of the strobe phase counter.
`define DPS_CNT_W 4
// Address and data widths of one port.
`define DPS_ADDR_W 14
`define DPS_DATA_W 16
// Position of the flag data bit and of the lane boundary.
`define DPS_FLAG_BIT 0
`define DPS_LANE_SPLIT 8
// Idle pin level: every control pin high.
`define DPS_PIN_IDLE 1'h1

`endif

// *** design/dps_pkg.sv ***
package dps_pkg;

    // Operations that the user side may request.
    typedef enum logic [1:0]
    {
        DPS_OP_READ       = 2'h0,
        DPS_OP_WRITE      = 2'h1,
        DPS_OP_FLAG_READ  = 2'h2,
        DPS_OP_FLAG_WRITE = 2'h3
    } dps_op_type;

    // One request from the user side.
    typedef struct packed
    {
        dps_op_type  op;
        logic [13:0] addr;
        logic [15:0] wdata;
        logic        high_lane;
        logic        low_lane;
    } dps_req_type;

    // Every pin that the controller drives into one memory port.
    typedef struct packed
    {
        logic        ce_n;
        logic        rw_n;
        logic        oe_n;
        logic        high_lane_select_n;
        logic        low_lane_select_n;
        logic        flag_access_n;
        logic [13:0] addr;
        logic [15:0] data_out;
        logic [15:0] data_oe;
    } dps_pins_type;

endpackage

// *** design/dps_port_host.sv ***
// Notes on behaviour
// - A write with the high lane selected writes bits 8 to 15.
// - A write with the low lane selected writes bits 0 to 7.
// - Normal behaviour holds only while the ports use different addresses.
// - A flag write loads data bit 0 on the rising read/write edge.
// - Devices cascade side by side to widen the word, one as master.
`timescale 1ns/1ps
`default_nettype none
`include "dps_params.svh"

module dps_port_host #(
    parameter int         ACCESS_CYCLES = `DPS_ACCESS_CYC,
    parameter logic       MASTER        = 1'h1
) (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  req_valid,
    input  wire dps_pkg::dps_req_type  req,
    output var  logic                  req_ready,
    output var  logic                  done,
    output var  logic [15:0]           rdata,
    output var  logic                  flag_value,
    output var  dps_pkg::dps_pins_type pins,
    input  wire logic [15:0]           data_in,
    input  wire logic                  busy_n,
    output var  logic                  ms_sel
);

    // Every check below samples on the rising clock and rests in reset.
    default clocking dps_cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    //------------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------------

    typedef enum logic [3:0]
    {
        DPS_IDLE   = 4'h1,
        DPS_SETUP  = 4'h2,
        DPS_ACCESS = 4'h4,
        DPS_HOLD   = 4'h8
    } dps_state_type;

    localparam logic [`DPS_CNT_W-1:0] ACC_CNT =
        `DPS_CNT_W'(ACCESS_CYCLES);

    dps_state_type          state;
    dps_state_type          next_state;
    logic [`DPS_CNT_W-1:0]  count;
    dps_pkg::dps_op_type    op;
    logic                   stall;

    // Tells whether an operation touches the flags instead of the array.
    function automatic logic dps_is_flag(input dps_pkg::dps_op_type o);
        dps_is_flag = (o == dps_pkg::DPS_OP_FLAG_READ) ||
                      (o == dps_pkg::DPS_OP_FLAG_WRITE);
    endfunction

    // Tells whether an operation drives data into the port.
    function automatic logic dps_is_write(input dps_pkg::dps_op_type o);
        dps_is_write = (o == dps_pkg::DPS_OP_WRITE) ||
                       (o == dps_pkg::DPS_OP_FLAG_WRITE);
    endfunction

    // Busy from a master only stretches array accesses, never flag ones.
    assign stall = !busy_n && !dps_is_flag(op);

    // Chooses the next phase of the access.
    always_comb
    begin
        next_state = state;
        case (state)
            DPS_IDLE:
                next_state = req_valid ? DPS_SETUP : DPS_IDLE;
            DPS_SETUP:
                next_state = DPS_ACCESS;
            DPS_ACCESS:
                if (count == `DPS_CNT_W'(1) && !stall)
                    next_state = DPS_HOLD;
            DPS_HOLD:
                next_state = DPS_IDLE;
            default:
                next_state = DPS_IDLE;
        endcase
    end

    // Holds the phase, the strobe counter and the taken operation.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state <= DPS_IDLE;
            count <= '0;
            op    <= dps_pkg::DPS_OP_READ;
        end
        else
        begin
            state <= next_state;
            if (state == DPS_IDLE && req_valid)
                op <= req.op;
            if (state == DPS_SETUP)
                count <= ACC_CNT;
            else if (state == DPS_ACCESS && !stall && count != '0)
                count <= count - `DPS_CNT_W'(1);
        end
    end

    //------------------------------------------------------------------
    // Port pins
    //------------------------------------------------------------------

    // Drives the port; every access starts from and returns to deselect.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            pins.ce_n               <= `DPS_PIN_IDLE;
            pins.rw_n               <= `DPS_PIN_IDLE;
            pins.oe_n               <= `DPS_PIN_IDLE;
            pins.high_lane_select_n <= `DPS_PIN_IDLE;
            pins.low_lane_select_n  <= `DPS_PIN_IDLE;
            pins.flag_access_n      <= `DPS_PIN_IDLE;
            pins.addr               <= '0;
            pins.data_out           <= '0;
            pins.data_oe            <= '0;
        end
        else
        begin
            case (state)
                DPS_IDLE:
                begin
                    if (req_valid)
                    begin
                        pins.addr <= req.addr;
                        if (dps_is_flag(req.op))
                        begin
                            // Chip enable and selects stay high here.
                            pins.flag_access_n <= 1'h0;
                            pins.data_out <=
                                {16{req.wdata[`DPS_FLAG_BIT]}};
                            pins.data_oe <=
                                {16{dps_is_write(req.op)}};
                        end
                        else
                        begin
                            pins.ce_n               <= 1'h0;
                            pins.high_lane_select_n <= !req.high_lane;
                            pins.low_lane_select_n  <= !req.low_lane;
                            pins.data_out           <= req.wdata;
                            pins.data_oe <= dps_is_write(req.op) ?
                                {{8{req.high_lane}},
                                 {8{req.low_lane}}} : 16'h0000;
                        end
                        // Reads float the bus before the port drives.
                        pins.oe_n <= dps_is_write(req.op);
                    end
                end
                DPS_SETUP:
                begin
                    pins.rw_n <= !dps_is_write(op);
                end
                DPS_ACCESS:
                begin
                    if (next_state == DPS_HOLD)
                    begin
                        // Rising read/write latches data, bus still held.
                        pins.rw_n <= 1'h1;
                        pins.oe_n <= 1'h1;
                    end
                end
                DPS_HOLD:
                begin
                    pins.ce_n               <= 1'h1;
                    pins.flag_access_n      <= 1'h1;
                    pins.high_lane_select_n <= 1'h1;
                    pins.low_lane_select_n  <= 1'h1;
                    pins.data_oe            <= '0;
                end
                default:
                begin
                    pins.rw_n <= 1'h1;
                end
            endcase
        end
    end

    // Fixes the cascade role of the attached device.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ms_sel <= 1'h1;
        end
        else
        begin
            ms_sel <= MASTER;
        end
    end

    //------------------------------------------------------------------
    // User answer
    //------------------------------------------------------------------

    // Captures read data at the end of the strobe and pulses done.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            req_ready  <= 1'h0;
            done       <= 1'h0;
            rdata      <= '0;
            flag_value <= 1'h0;
        end
        else
        begin
            req_ready <= (next_state == DPS_IDLE);
            done      <= (state == DPS_HOLD);
            if (state == DPS_ACCESS && next_state == DPS_HOLD &&
                !dps_is_write(op))
            begin
                rdata <= data_in;
                if (dps_is_flag(op))
                    flag_value <= data_in[`DPS_FLAG_BIT];
            end
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------

    // Never the prohibited mix of flag access and array selection.
    a_no_prohibited_mix: assert property (
        !(!pins.flag_access_n && !pins.ce_n &&
          (!pins.high_lane_select_n || !pins.low_lane_select_n)))
        else $error("flag access overlaps array selection");
    // The bus is never driven while the port may be driving it.
    a_read_bus_free: assert property (
        !pins.oe_n |-> pins.data_oe == 16'h0000)
        else $error("bus driven during read");
    // An array write drives exactly the selected lanes while the strobe is low.
    a_write_lanes: assert property (
        (!pins.rw_n && !pins.ce_n) |->
        pins.data_oe == {{8{!pins.high_lane_select_n}},
                         {8{!pins.low_lane_select_n}}})
        else $error("write lanes differ from selects");
    // A flag write still drives bit 0 when read/write rises.
    a_flag_edge_data: assert property (
        ($rose(pins.rw_n) && !pins.flag_access_n) |->
        (pins.data_oe[`DPS_FLAG_BIT] && pins.ce_n &&
         pins.high_lane_select_n && pins.low_lane_select_n))
        else $error("flag write edge without held data");
    // Idle leaves the port deselected with the bus floating.
    a_idle_deselect: assert property (
        (state == DPS_IDLE) |->
        (pins.ce_n && pins.flag_access_n && pins.data_oe == 16'h0000))
        else $error("port not deselected while idle");
    // The address holds still for the whole strobe phase.
    a_addr_stable: assert property (
        (state == DPS_ACCESS) |=> $stable(pins.addr))
        else $error("address moved during access");
    // Without busy an access completes after the set strobe length.
    a_access_length: assert property (
        (state == DPS_SETUP && busy_n) ##1 busy_n [*3] |->
        ##[0:1] (state == DPS_HOLD))
        else $error("access length wrong");
    // Done is a single cycle pulse that follows the hold phase.
    a_done_pulse: assert property (
        $rose(done) |-> $past(state) == DPS_HOLD ##1 !done)
        else $error("done not a one cycle pulse");
    // Busy low keeps an array write strobe low.
    a_busy_stretch: assert property (
        (state == DPS_ACCESS && !busy_n && !dps_is_flag(op) &&
         !pins.rw_n) |=> !pins.rw_n)
        else $error("strobe ended under busy");

    c_array_write: cover property (!pins.rw_n && !pins.ce_n ##[1:8] done);
    c_array_read: cover property (!pins.oe_n && !pins.ce_n ##[1:8] done);
    c_flag_write: cover property ($rose(pins.rw_n) && !pins.flag_access_n);
    c_busy_stall: cover property (state == DPS_ACCESS && stall);
endmodule

`default_nettype wire

// *** testbench/dps_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------
// One memory port, answering at its pins without a clock.
// ----------
module dps_mem_model (
    input  wire dps_pkg::dps_pins_type pins,
    input  wire logic [15:0]           bus,
    output var  logic [15:0]           drv_data,
    output var  logic [15:0]           drv_oe
);
    // One port only: the far port never shares an address, so no contention.
    logic [15:0] mem [16384];
    logic        flag [8];
    logic        arr_sel;
    logic        flag_sel;

    // Array access needs chip enable, flag access needs chip enable off or no lane selected.
    assign arr_sel  = !pins.ce_n && pins.flag_access_n;
    assign flag_sel = !pins.flag_access_n && (pins.ce_n
        || (pins.high_lane_select_n && pins.low_lane_select_n));

    // The lanes float unless a read is enabled, and then only selected ones for the array, all of them for a flag.
    always_comb
    begin
        drv_oe   = 16'h0;
        drv_data = 16'h0;
        if (!pins.oe_n && pins.rw_n && arr_sel)
        begin
            drv_oe   = {{8{!pins.high_lane_select_n}},
                        {8{!pins.low_lane_select_n}}};
            drv_data = mem[pins.addr];
        end
        else if (!pins.oe_n && pins.rw_n && flag_sel)
        begin
            drv_oe   = 16'hffff;
            drv_data = {16{flag[pins.addr[2:0]]}};
        end
    end

    // Writes land on the rising edge of read/write, with no clock.
    always @(posedge pins.rw_n)
    begin
        if (arr_sel && !pins.high_lane_select_n)
            mem[pins.addr][15:8] = bus[15:8];
        if (arr_sel && !pins.low_lane_select_n)
            mem[pins.addr][7:0] = bus[7:0];
        if (flag_sel)
            flag[pins.addr[2:0]] = bus[0];
    end
endmodule
`default_nettype wire

// *** testbench/dps_port_host_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module dps_port_host_tb;
    // ----------
    // Signals and the device under test
    // ----------
    localparam int         ACC = 3;
    logic                  clock = 1'h0;
    logic                  rstn = 1'h0;
    logic                  req_valid = 1'h0;
    dps_pkg::dps_req_type  req = '0;
    logic                  req_ready, done, flag_value, ms_sel;
    logic [15:0]           rdata, bus, m_data, m_oe;
    logic [15:0]           last_bus = 16'h0;
    logic                  busy_n = 1'h1;
    logic                  stall = 1'h0;
    dps_pkg::dps_pins_type pins;
    int                    mismatches = 0;
    int                    cmp_count = 0;
    logic [15:0]           ref_mem [int];
    logic                  ref_flag [8];

    always #12.5 clock = ~clock;

    dps_port_host #(.ACCESS_CYCLES(ACC)) i_dps_port_host (
        .clock(clock), .rstn(rstn), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .rdata(rdata),
        .flag_value(flag_value), .pins(pins), .data_in(bus),
        .busy_n(busy_n), .ms_sel(ms_sel));

    dps_mem_model i_dps_mem_model (
        .pins(pins), .bus(bus), .drv_data(m_data), .drv_oe(m_oe));

    // Lines nobody drives show the inverse of the last cycle's level.
    assign bus = (pins.data_oe & pins.data_out) | (m_oe & m_data)
               | (~pins.data_oe & ~m_oe & ~last_bus);

    // A master device stalls array accesses at random while enabled.
    always @(posedge clock)
    begin
        last_bus <= rstn ? bus : 16'ha5a5;
        busy_n   <= !stall || ($urandom_range(2) != 0);
    end

    // ----------
    // Checking and closing
    // ----------
    task automatic cmp_word(input string name, input logic [15:0] exp,
        input logic [15:0] got, input logic [15:0] mask);
        cmp_count++;
        if ((got & mask) !== (exp & mask))
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp & mask,
                got & mask);
        end
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Pin-level watch: no clash, no forbidden mix, floating when disabled.
    always @(posedge clock)
    begin
        if (rstn)
        begin
            cmp_word("bus_clash", 16'h0, pins.data_oe & m_oe, 16'hffff);
            cmp_word("bad_mix", 16'h0, {15'h0, !pins.flag_access_n
                && !pins.ce_n && !(pins.high_lane_select_n
                && pins.low_lane_select_n)}, 16'h1);
            if (pins.oe_n)
                cmp_word("oe_float", 16'h0, m_oe, 16'hffff);
        end
    end

    // ----------
    // Bus operations
    // ----------
    task automatic run_op(input dps_pkg::dps_op_type op,
        input logic [13:0] a, input logic [15:0] d, input logic hi,
        input logic lo);
        int n;
        req       <= '{op, a, d, hi, lo};
        req_valid <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (req_ready !== 1'h1 && n < 40);
        req_valid <= 1'h0;
        if (req_ready !== 1'h1)
        begin
            mismatches++;
            end_of_test();
        end
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (done !== 1'h1 && n < 300);
        if (done !== 1'h1)
        begin
            mismatches++;
            end_of_test();
        end
        if (!stall || op[1])
            cmp_word("latency", 16'(ACC + 3), 16'(n), 16'hffff);
    endtask

    task automatic wr(input logic [13:0] a, input logic [15:0] d,
        input logic hi, input logic lo);
        logic [15:0] m;
        m = {{8{hi}}, {8{lo}}};
        run_op(dps_pkg::DPS_OP_WRITE, a, d, hi, lo);
        ref_mem[a] = (d & m) | (ref_mem[a] & ~m);
    endtask

    task automatic rd(input logic [13:0] a, input logic hi, input logic lo);
        run_op(dps_pkg::DPS_OP_READ, a, 16'($urandom), hi, lo);
        cmp_word("rdata", ref_mem[a], rdata, {{8{hi}}, {8{lo}}});
    endtask

    task automatic fl(input logic [2:0] f, input logic v);
        run_op(dps_pkg::DPS_OP_FLAG_WRITE, {11'($urandom), f},
            {15'($urandom), v}, 1'h0, 1'h0);
        ref_flag[f] = v;
    endtask

    // ----------
    // Main sequence
    // ----------
    initial
    begin
        int          seed;
        logic [13:0] a;
        seed = $urandom(84);
        repeat (4) @(posedge clock);
        rstn <= 1'h1;
        repeat (2) @(posedge clock);
        cmp_word("ms_sel", 16'h1, {15'h0, ms_sel}, 16'h1);
        cmp_word("idle", 16'h3, {14'h0, pins.ce_n, pins.flag_access_n},
            16'h3);
        cmp_word("idle_oe", 16'h0, pins.data_oe, 16'hffff);
        // Whole words at both ends of the array and at random places.
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 0) ? 14'h0 : (i == 1) ? 14'h3fff : 14'($urandom);
            wr(a, 16'($urandom), 1'h1, 1'h1);
            rd(a, 1'h1, 1'h1);
        end
        $display("Test words done");
        // Every lane pattern written to one word, none included.
        for (int l = 0; l < 4; l++)
        begin
            wr(a, 16'($urandom), l[1], l[0]);
            for (int k = 1; k < 4; k++)
                rd(a, k[1], k[0]);
        end
        $display("Test lanes done");
        // Every flag, reached through varying upper address bits.
        for (int f = 0; f < 8; f++)
            fl(f[2:0], 1'($urandom));
        for (int f = 0; f < 8; f++)
        begin
            run_op(dps_pkg::DPS_OP_FLAG_READ, {11'($urandom), f[2:0]},
                16'h0, 1'h0, 1'h0);
            cmp_word("flag_bus", {16{ref_flag[f]}}, rdata, 16'hffff);
            cmp_word("flag_value", {15'h0, ref_flag[f]},
                {15'h0, flag_value}, 16'h1);
        end
        $display("Test flags done");
        // Random traffic while the busy input stalls array accesses.
        stall = 1'h1;
        for (int i = 0; i < 20; i++)
        begin
            a = 14'($urandom);
            wr(a, 16'($urandom), 1'h1, 1'h1);
            rd(a, 1'h1, 1'h1);
            fl(a[2:0], ~ref_flag[a[2:0]]);
        end
        $display("Test stall done");
        end_of_test();
    end
endmodule
`default_nettype wire
